// >>> include/tpw_pkg.sv
// Constants, encodings and carrier types for the timer PWM unit.
// Assumes an APB master with 32-bit data and byte-wide registers in the low lane.
package tpw_pkg;

    // Register byte addresses; each register takes one aligned word.
    localparam logic [7:0] TSC_OFF    = 8'h00;
    localparam logic [7:0] CNTH_OFF   = 8'h04;
    localparam logic [7:0] CNTL_OFF   = 8'h08;
    localparam logic [7:0] MODH_OFF   = 8'h0C;
    localparam logic [7:0] MODL_OFF   = 8'h10;
    localparam logic [7:0] CH_BASE    = 8'h20;
    localparam logic [7:0] CH_STRIDE  = 8'h10;
    localparam logic [7:0] CSC_OFF    = 8'h00;
    localparam logic [7:0] CVH_OFF    = 8'h04;
    localparam logic [7:0] CVL_OFF    = 8'h08;

    // Field positions of timer_status_control.
    localparam int TSC_CLOCK_SELECT_FIELD_LSB  = 0;
    localparam int TSC_CENTER_ALIGNED_SELECT_BIT = 5;
    localparam int TSC_OVERFLOW_IRQ_ENABLE_BIT  = 6;
    localparam int TSC_TOF_BIT   = 7;
    localparam logic [7:0] TSC_WMASK = 8'h63;
    localparam logic [7:0] TSC_FMASK = 8'h80;

    // Field positions of channel_status_control.
    localparam int CSC_ELSA_BIT = 2;
    localparam int CSC_ELSB_BIT = 3;
    localparam int CSC_MSA_BIT  = 4;
    localparam int CSC_MSB_BIT  = 5;
    localparam int CSC_CHIE_BIT = 6;
    localparam int CSC_CHF_BIT  = 7;
    localparam logic [7:0] CSC_WMASK = 8'h7C;
    localparam logic [7:0] CSC_FMASK = 8'h80;

    // Reset values and counter landmarks.
    localparam logic [7:0]  TSC_RST   = 8'h00;
    localparam logic [7:0]  CSC_RST   = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] MOD_RST   = 16'h0000;
    localparam logic [15:0] CV_RST    = 16'h0000;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] MOD_FREE  = 16'h0000;

    // Counter clock selection codes.
    typedef enum logic [1:0] {
        TPW_CLK_NONE  = 2'h0,
        TPW_CLK_BUS   = 2'h1,
        TPW_CLK_FIXED = 2'h2,
        TPW_CLK_EXT   = 2'h3
    } tpw_clock_select_field_t;

    // Counting direction of the up/down counter.
    typedef enum logic {
        TPW_UP   = 1'b0,
        TPW_DOWN = 1'b1
    } tpw_dir_t;

    // APB request from the master.
    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } tpw_apb_req_t;

    // Per-channel state.
    typedef struct packed {
        logic [7:0]  csc;
        logic [15:0] cv;
        logic [7:0]  buf_h;
        logic [7:0]  buf_l;
        logic        got_h;
        logic        got_l;
        logic        chf_arm;
        logic        in_s1;
        logic        in_s2;
        logic        in_s3;
    } tpw_chan_t;

endpackage

// >>> hdl/tpw_timer_pwm_unit.sv
// Timer PWM unit: 16-bit counter, modulus, channels with PWM, compare and capture.
// Assumes one 100 MHz clock, an APB master, and pads that resolve pin enables.
//
// Summary of operation
// - Edge-aligned: counter counts up; period is modulus plus one counter clock.
// - Edge-aligned: polarity 0 drives high on overflow, low on match; 1 inverts.
// - Edge-aligned: value zero stays inactive; value above modulus stays active.
// - Value bytes go to a buffer; with clock off, load on second byte.
// - With clock on, load when counter steps from terminal minus one to terminal.
// - Center-aligned: count up to modulus then down to zero; period twice modulus.
// - Center-aligned: active pulse width is twice the channel value when below modulus.
// - Center-aligned, polarity 0: up-count match drives low, down-count match high.
// - Center-aligned: zero or negative value gives 0%; above modulus gives 100%.
// - Edge mode with zero modulus: counter runs free and wraps 0xFFFF to 0x0000.
// - Modulus and channel value writes land in buffers, not active registers.
// - Status/control writes discard pending modulus or channel value bytes.
// - Reset clears control, modes and edges; channels become idle inputs.
// - Channel flag sets on capture edge, or on counter match in compare/PWM.
// - Each interrupt output is a high level while flag and enable are set.
// - A flag clears only by reading it set, then writing zero.
// - An event between the read and the zero write keeps the flag set.
// - Center-aligned: overflow flag sets at end of the count equal to modulus.
// - Edge-aligned channels share the up-counter with capture and compare channels.
// - Clock select: 00 stopped, 01 bus, 10 fixed clock, 11 external pin.
// - Up-count with modulus: overflow flag sets on modulus to zero transition.
`timescale 1ns/1ps

module tpw_timer_pwm_unit #(
    parameter int NCH       = 2,
    parameter int FIXED_DIV = 4
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    input  wire tpw_pkg::tpw_apb_req_t apb_i,
    output logic [31:0]                prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  ext_clk_i,
    input  wire logic [NCH-1:0]        ch_in_i,
    output logic [NCH-1:0]             ch_out_o,
    output logic [NCH-1:0]             ch_oe_o,
    output logic                       irq_ovf_o,
    output logic [NCH-1:0]             irq_ch_o
);

    // Refuse channel counts and divider ratios the address map and divider cannot hold.
    if (NCH < 1 || NCH > 8 || FIXED_DIV < 1 || FIXED_DIV > 256) begin : g_bad_param
        $error("tpw_timer_pwm_unit: NCH must be 1..8 and FIXED_DIV 1..256");
    end

    // All state of the unit.
    typedef struct packed {
        logic [31:0]                   prdata;
        logic                          pready;
        logic                          pslverr;
        logic [7:0]                    tsc;
        logic                          tof_arm;
        logic [15:0]                   cnt;
        tpw_pkg::tpw_dir_t             dir;
        logic [15:0]                   mod;
        logic [7:0]                    mbuf_h;
        logic [7:0]                    mbuf_l;
        logic                          got_mh;
        logic                          got_ml;
        logic [7:0]                    div;
        logic                          ext_s1;
        logic                          ext_s2;
        logic                          ext_s3;
        tpw_pkg::tpw_chan_t [NCH-1:0]  ch;
        logic [NCH-1:0]                pin_out;
        logic [NCH-1:0]                pin_oe;
        logic [NCH-1:0]                irq_ch;
        logic                          irq_ovf;
    } tpw_state_t;

    tpw_state_t          r;
    tpw_state_t          next_r;
    tpw_pkg::tpw_clock_select_field_t  clock_select_field;
    logic                setup, acc_wr, acc_rd, mapped, cnt_wr;
    logic                hit_tsc, hit_cnth, hit_cntl, hit_modh, hit_modl;
    logic [NCH-1:0]      hit_csc, hit_cvh, hit_cvl;
    logic                fix_tick, tick, ovf, mv_up, upd, center_aligned_select;
    logic [15:0]         term, nc;
    logic [NCH-1:0]      m_cap, m_oc, m_edge, match;

    // Bus phase qualifiers; a transfer completes at the edge where pready is seen high.
    assign setup   = apb_i.psel & ~apb_i.penable;
    assign acc_wr  = apb_i.psel & apb_i.penable & r.pready & apb_i.pwrite;
    assign acc_rd  = apb_i.psel & apb_i.penable & r.pready & ~apb_i.pwrite;

    // Timer-wide address decode.
    assign hit_tsc  = (apb_i.paddr == tpw_pkg::TSC_OFF);
    assign hit_cnth = (apb_i.paddr == tpw_pkg::CNTH_OFF);
    assign hit_cntl = (apb_i.paddr == tpw_pkg::CNTL_OFF);
    assign hit_modh = (apb_i.paddr == tpw_pkg::MODH_OFF);
    assign hit_modl = (apb_i.paddr == tpw_pkg::MODL_OFF);
    assign mapped   = hit_tsc | hit_cnth | hit_cntl | hit_modh | hit_modl
                    | (|hit_csc) | (|hit_cvh) | (|hit_cvl);
    assign cnt_wr   = acc_wr & (hit_cnth | hit_cntl);
    assign clock_select_field     = tpw_pkg::tpw_clock_select_field_t'(r.tsc[tpw_pkg::TSC_CLOCK_SELECT_FIELD_LSB +: 2]);
    assign center_aligned_select    = r.tsc[tpw_pkg::TSC_CENTER_ALIGNED_SELECT_BIT];
    assign fix_tick = (r.div == 8'(FIXED_DIV - 1));

    // Per-channel address decode and mode decode; compare channels share the counter.
    for (genvar gi = 0; gi < NCH; gi++) begin : g_chan_dec
        localparam logic [7:0] CB = 8'(tpw_pkg::CH_BASE + gi * tpw_pkg::CH_STRIDE);
        assign hit_csc[gi] = (apb_i.paddr == 8'(CB + tpw_pkg::CSC_OFF));
        assign hit_cvh[gi] = (apb_i.paddr == 8'(CB + tpw_pkg::CVH_OFF));
        assign hit_cvl[gi] = (apb_i.paddr == 8'(CB + tpw_pkg::CVL_OFF));
        assign m_cap[gi]  = ~center_aligned_select & ~r.ch[gi].csc[tpw_pkg::CSC_MSB_BIT]
                          & ~r.ch[gi].csc[tpw_pkg::CSC_MSA_BIT];
        assign m_oc[gi]   = ~center_aligned_select & ~r.ch[gi].csc[tpw_pkg::CSC_MSB_BIT]
                          & r.ch[gi].csc[tpw_pkg::CSC_MSA_BIT];
        assign m_edge[gi] = ~center_aligned_select & r.ch[gi].csc[tpw_pkg::CSC_MSB_BIT];
        assign match[gi]  = tick & ~m_cap[gi] & (nc == r.ch[gi].cv);
    end

    // Next-state logic for the whole unit.
    always_comb begin
        logic [7:0] rd_byte;
        logic [1:0] els;
        logic       rise, fall, cap_ev, act, po;
        rd_byte = 8'h00;
        els     = 2'h0;
        rise    = 1'b0;
        fall    = 1'b0;
        cap_ev  = 1'b0;
        act     = 1'b0;
        po      = 1'b0;
        next_r  = r;

        // Answer every setup cycle in the following access cycle.
        next_r.pready  = setup;
        next_r.pslverr = setup & ~mapped;
        // Counter clock enables; a counter write suppresses the step.
        next_r.div    = fix_tick ? 8'h00 : 8'(r.div + 8'h01);
        next_r.ext_s1 = ext_clk_i;
        next_r.ext_s2 = r.ext_s1;
        next_r.ext_s3 = r.ext_s2;
        case (clock_select_field)
            tpw_pkg::TPW_CLK_BUS:   tick = ~cnt_wr;
            tpw_pkg::TPW_CLK_FIXED: tick = fix_tick & ~cnt_wr;
            tpw_pkg::TPW_CLK_EXT:   tick = r.ext_s2 & ~r.ext_s3 & ~cnt_wr;
            default:                tick = 1'b0;
        endcase
        // Counter stepping in up or up/down mode.
        term  = (r.mod == tpw_pkg::MOD_FREE) ? tpw_pkg::CNT_MAX : r.mod;
        nc    = r.cnt;
        ovf   = 1'b0;
        mv_up = 1'b0;
        if (tick) begin
            if (!center_aligned_select) begin
                if (r.cnt == term) begin
                    nc  = tpw_pkg::CNT_ZERO;
                    ovf = 1'b1;
                end else begin
                    nc    = r.cnt + tpw_pkg::CNT_ONE;
                    mv_up = 1'b1;
                end
            end else if (r.dir == tpw_pkg::TPW_UP) begin
                if (r.cnt >= r.mod) begin
                    nc         = r.cnt - tpw_pkg::CNT_ONE;
                    next_r.dir = tpw_pkg::TPW_DOWN;
                    ovf        = 1'b1;
                end else begin
                    nc    = r.cnt + tpw_pkg::CNT_ONE;
                    mv_up = 1'b1;
                end
            end else if (r.cnt == tpw_pkg::CNT_ZERO) begin
                nc         = tpw_pkg::CNT_ONE;
                next_r.dir = tpw_pkg::TPW_UP;
                mv_up      = 1'b1;
            end else begin
                nc = r.cnt - tpw_pkg::CNT_ONE;
            end
        end
        upd        = tick & mv_up & (nc == term);
        next_r.cnt = nc;
        if (cnt_wr) begin
            next_r.cnt = tpw_pkg::CNT_ZERO;
            next_r.dir = tpw_pkg::TPW_UP;
        end
        // Timer control write discards modulus bytes; flag needs read then zero write.
        if (acc_wr && hit_tsc) begin
            next_r.tsc     = (apb_i.pwdata[7:0] & tpw_pkg::TSC_WMASK)
                           | (r.tsc & tpw_pkg::TSC_FMASK);
            next_r.got_mh  = 1'b0;
            next_r.got_ml  = 1'b0;
            next_r.tof_arm = 1'b0;
            if (!apb_i.pwdata[tpw_pkg::TSC_TOF_BIT] && r.tof_arm) begin
                next_r.tsc[tpw_pkg::TSC_TOF_BIT] = 1'b0;
            end
        end
        if (acc_rd && hit_tsc && r.tsc[tpw_pkg::TSC_TOF_BIT]) begin
            next_r.tof_arm = 1'b1;
        end
        if (ovf) begin
            next_r.tsc[tpw_pkg::TSC_TOF_BIT] = 1'b1;
            next_r.tof_arm                   = 1'b0;
        end
        next_r.irq_ovf = next_r.tsc[tpw_pkg::TSC_TOF_BIT]
                       & next_r.tsc[tpw_pkg::TSC_OVERFLOW_IRQ_ENABLE_BIT];
        // Modulus bytes are buffered and move as a pair.
        if (acc_wr && hit_modh) begin
            next_r.mbuf_h = apb_i.pwdata[7:0];
            next_r.got_mh = 1'b1;
        end
        if (acc_wr && hit_modl) begin
            next_r.mbuf_l = apb_i.pwdata[7:0];
            next_r.got_ml = 1'b1;
        end
        if (next_r.got_mh && next_r.got_ml && (clock_select_field == tpw_pkg::TPW_CLK_NONE || upd)) begin
            next_r.mod    = {next_r.mbuf_h, next_r.mbuf_l};
            next_r.got_mh = 1'b0;
            next_r.got_ml = 1'b0;
        end
        // Channels: control, value buffering, capture, flags and pin drive.
        for (int i = 0; i < NCH; i++) begin
            els    = {r.ch[i].csc[tpw_pkg::CSC_ELSB_BIT], r.ch[i].csc[tpw_pkg::CSC_ELSA_BIT]};
            next_r.ch[i].in_s1 = ch_in_i[i];
            next_r.ch[i].in_s2 = r.ch[i].in_s1;
            next_r.ch[i].in_s3 = r.ch[i].in_s2;
            rise   = r.ch[i].in_s2 & ~r.ch[i].in_s3;
            fall   = ~r.ch[i].in_s2 & r.ch[i].in_s3;
            cap_ev = m_cap[i] & ((els == 2'h1 & rise) | (els == 2'h2 & fall)
                   | (els == 2'h3 & (rise | fall)));
            if (acc_wr && hit_csc[i]) begin
                next_r.ch[i].csc     = (apb_i.pwdata[7:0] & tpw_pkg::CSC_WMASK)
                                     | (r.ch[i].csc & tpw_pkg::CSC_FMASK);
                next_r.ch[i].got_h   = 1'b0;
                next_r.ch[i].got_l   = 1'b0;
                next_r.ch[i].chf_arm = 1'b0;
                if (!apb_i.pwdata[tpw_pkg::CSC_CHF_BIT] && r.ch[i].chf_arm) begin
                    next_r.ch[i].csc[tpw_pkg::CSC_CHF_BIT] = 1'b0;
                end
            end
            if (acc_rd && hit_csc[i] && r.ch[i].csc[tpw_pkg::CSC_CHF_BIT]) begin
                next_r.ch[i].chf_arm = 1'b1;
            end
            if (acc_wr && hit_cvh[i]) begin
                next_r.ch[i].buf_h = apb_i.pwdata[7:0];
                next_r.ch[i].got_h = 1'b1;
            end
            if (acc_wr && hit_cvl[i]) begin
                next_r.ch[i].buf_l = apb_i.pwdata[7:0];
                next_r.ch[i].got_l = 1'b1;
            end
            if (next_r.ch[i].got_h && next_r.ch[i].got_l
                    && (clock_select_field == tpw_pkg::TPW_CLK_NONE || upd)) begin
                next_r.ch[i].cv    = {next_r.ch[i].buf_h, next_r.ch[i].buf_l};
                next_r.ch[i].got_h = 1'b0;
                next_r.ch[i].got_l = 1'b0;
            end
            if (cap_ev) begin
                next_r.ch[i].cv = r.cnt;
            end
            if (cap_ev || match[i]) begin
                next_r.ch[i].csc[tpw_pkg::CSC_CHF_BIT] = 1'b1;
                next_r.ch[i].chf_arm                   = 1'b0;
            end
            next_r.irq_ch[i] = next_r.ch[i].csc[tpw_pkg::CSC_CHF_BIT]
                             & next_r.ch[i].csc[tpw_pkg::CSC_CHIE_BIT];
            // Pin level; active level is high when the polarity bit is clear.
            act = ~r.ch[i].csc[tpw_pkg::CSC_ELSA_BIT];
            po  = r.pin_out[i];
            if (m_edge[i]) begin
                if (ovf) begin
                    po = act;
                end
                if (match[i] || r.ch[i].cv == tpw_pkg::CNT_ZERO) begin
                    po = ~act;
                end
            end else if (center_aligned_select) begin
                if (r.ch[i].cv == tpw_pkg::CNT_ZERO || r.ch[i].cv[15]) begin
                    po = ~act;
                end else if (r.ch[i].cv > r.mod) begin
                    po = act;
                end else if (match[i]) begin
                    po = mv_up ? ~act : act;
                end
            end else if (m_oc[i]) begin
                if (match[i]) begin
                    case (els)
                        2'h1:    po = ~po;
                        2'h2:    po = 1'b0;
                        2'h3:    po = 1'b1;
                        default: po = r.pin_out[i];
                    endcase
                end
            end else begin
                po = 1'b0;
            end
            next_r.pin_out[i] = po;
            next_r.pin_oe[i]  = (els != 2'h0) & ~m_cap[i];
        end
        // Read data is captured in the setup cycle and stands through the access.
        if (hit_tsc) begin
            rd_byte = r.tsc;
        end else if (hit_cnth) begin
            rd_byte = r.cnt[15:8];
        end else if (hit_cntl) begin
            rd_byte = r.cnt[7:0];
        end else if (hit_modh) begin
            rd_byte = r.mod[15:8];
        end else if (hit_modl) begin
            rd_byte = r.mod[7:0];
        end
        for (int i = 0; i < NCH; i++) begin
            if (hit_csc[i]) begin
                rd_byte = r.ch[i].csc;
            end else if (hit_cvh[i]) begin
                rd_byte = r.ch[i].cv[15:8];
            end else if (hit_cvl[i]) begin
                rd_byte = r.ch[i].cv[7:0];
            end
        end
        if (setup) begin
            next_r.prdata = {24'h00_0000, rd_byte};
        end
    end

    // State register; reset stops the clock, clears modes and releases the pins.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r     <= '0;
            r.tsc <= tpw_pkg::TSC_RST;
            r.cnt <= tpw_pkg::CNT_RST;
            r.mod <= tpw_pkg::MOD_RST;
            r.dir <= tpw_pkg::TPW_UP;
            for (int i = 0; i < NCH; i++) begin
                r.ch[i].csc <= tpw_pkg::CSC_RST;
                r.ch[i].cv  <= tpw_pkg::CV_RST;
            end
        end else begin
            r <= next_r;
        end
    end
    // Outputs come straight from the state register.
    assign prdata_o  = r.prdata;
    assign pready_o  = r.pready;
    assign pslverr_o = r.pslverr;
    assign ch_out_o  = r.pin_out;
    assign ch_oe_o   = r.pin_oe;
    assign irq_ovf_o = r.irq_ovf;
    assign irq_ch_o  = r.irq_ch;

    // Checks on counter, flags, buffering and pin levels.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_up_step: assert property (
        (!center_aligned_select && tick && r.cnt != term) |=> (r.cnt == $past(r.cnt) + tpw_pkg::CNT_ONE))
        else $error("up counter did not step by one");
    a_ovf_wrap: assert property (
        (!center_aligned_select && tick && r.cnt == term)
            |=> (r.cnt == tpw_pkg::CNT_ZERO && r.tsc[tpw_pkg::TSC_TOF_BIT]))
        else $error("terminal count did not wrap to zero with overflow flag");
    a_center_turn: assert property (
        (center_aligned_select && tick && r.dir == tpw_pkg::TPW_UP && r.cnt == r.mod && r.mod != 16'h0000)
            |=> (r.dir == tpw_pkg::TPW_DOWN && r.tsc[tpw_pkg::TSC_TOF_BIT]
                 && r.cnt == $past(r.mod) - tpw_pkg::CNT_ONE))
        else $error("center counter did not turn down at modulus");
    a_irq_level: assert property (
        irq_ovf_o == (r.tsc[tpw_pkg::TSC_TOF_BIT] && r.tsc[tpw_pkg::TSC_OVERFLOW_IRQ_ENABLE_BIT]))
        else $error("overflow request differs from flag and enable");
    a_flag_keep_unarmed: assert property (
        (acc_wr && hit_tsc && !apb_i.pwdata[7] && !r.tof_arm && r.tsc[7])
            |=> r.tsc[tpw_pkg::TSC_TOF_BIT])
        else $error("overflow flag cleared without a prior read");
    a_flag_set_wins: assert property (
        (ovf && acc_wr && hit_tsc) |=> (r.tsc[tpw_pkg::TSC_TOF_BIT] && !r.tof_arm))
        else $error("new overflow lost during clear sequence");
    a_edge_zero_duty: assert property (
        (m_edge[0] && tick && r.ch[0].cv == tpw_pkg::CNT_ZERO && !cnt_wr
            && $stable(r.ch[0].csc))
            |=> (ch_out_o[0] == $past(r.ch[0].csc[tpw_pkg::CSC_ELSA_BIT])))
        else $error("zero value did not keep the edge PWM output inactive");
    a_cv_load_stop: assert property (
        (acc_wr && hit_cvl[0] && r.ch[0].got_h && clock_select_field == tpw_pkg::TPW_CLK_NONE)
            |=> (r.ch[0].cv == {$past(r.ch[0].buf_h), $past(apb_i.pwdata[7:0])}))
        else $error("channel value not loaded on second byte with clock off");
    a_csc_discard: assert property (
        (acc_wr && hit_csc[0]) |=> (!r.ch[0].got_h && !r.ch[0].got_l))
        else $error("channel control write did not discard value bytes");
    a_center_up_match: assert property (
        (center_aligned_select && match[0] && mv_up && r.ch[0].cv != 16'h0000 && !r.ch[0].cv[15]
            && r.ch[0].cv <= r.mod && !(acc_wr && hit_csc[0]))
            |=> (ch_out_o[0] == r.ch[0].csc[tpw_pkg::CSC_ELSA_BIT]))
        else $error("up-count match did not drive the inactive level");

endmodule // tpw_timer_pwm_unit

// >>> verification/tpw_pin_model.sv
// Pad model for the channel pins of the timer PWM unit.
// Assumes a pull-up on every channel pad; the pin level feeds back to the capture inputs.
`timescale 1ns/1ps
module tpw_pin_model #(
    parameter int NCH = 2
) (
    input  wire logic [NCH-1:0] out_i,
    input  wire logic [NCH-1:0] oe_i,
    output logic [NCH-1:0]      pin_o
);
    // A released pad floats up to the pull-up level.
    assign pin_o = (oe_i & out_i) | ~oe_i;
endmodule // tpw_pin_model

// >>> verification/testbench.sv
// Self-checking bench for the timer PWM unit, driven over APB.
// Assumes the package and the pad model are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, a, e); end end
module testbench;
    logic                  mclk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    tpw_pkg::tpw_apb_req_t req = '0;
    logic [31:0]           prdata, rdv;
    logic                  pready, pslverr, irq_ovf, err;
    logic [1:0]            ch_out, ch_oe, pin, irq_ch;
    int                    mismatches = 0;
    int                    total_checks = 0;
    int                    hi;
    tpw_timer_pwm_unit #(.NCH(2), .FIXED_DIV(1)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .apb_i(req), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .ext_clk_i(1'b0), .ch_in_i(pin), .ch_out_o(ch_out), .ch_oe_o(ch_oe),
        .irq_ovf_o(irq_ovf), .irq_ch_o(irq_ch));
    tpw_pin_model #(.NCH(2)) i_pads (.out_i(ch_out), .oe_i(ch_oe), .pin_o(pin));
    // One APB transfer; holds the request until pready is seen at an edge.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge mclk_i);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h00_0000, d}};
        @(posedge mclk_i);
        req.penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // Reads a register and compares the byte it returns.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        `CHK(rdv, {24'h00_0000, e})
    endtask
    // Counts the cycles in which channel 0's pin is high.
    task automatic meas(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge mclk_i);
            hi += (pin[0] === 1'b1) ? 1 : ((pin[0] === 1'b0) ? 0 : 1000); // Unknown spoils it.
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic close_out;
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Free-running bus clock.
    initial forever #5 mclk_i = ~mclk_i;
    // Cuts a hang short.
    initial begin
        #200_000;
        mismatches++;
        close_out();
    end
    // Main test sequence.
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h20, 8'h00);
        `CHK(ch_oe, 2'b00)
        xfer(8'h14, 1'b1, 8'hFF);
        `CHK(err, 1'b1)
        xfer(8'h24, 1'b1, 8'h12);
        xfer(8'h20, 1'b1, 8'h28);
        xfer(8'h28, 1'b1, 8'h02);
        rd(8'h24, 8'h00);
        rd(8'h28, 8'h00);
        xfer(8'h24, 1'b1, 8'h00);
        rd(8'h28, 8'h02);
        xfer(8'h0C, 1'b1, 8'h00);
        xfer(8'h10, 1'b1, 8'h04);
        rd(8'h10, 8'h04);
        xfer(8'h00, 1'b1, 8'h41);
        repeat (10) @(posedge mclk_i);
        meas(40);
        `CHK(hi, 16)
        `CHK(irq_ovf, 1'b1)
        rd(8'h20, 8'hA8);
        `CHK(irq_ch, 2'b00)
        xfer(8'h00, 1'b1, 8'h40);
        rd(8'h00, 8'hC0);
        xfer(8'h00, 1'b1, 8'h40);
        rd(8'h00, 8'h40);
        `CHK(irq_ovf, 1'b0)
        xfer(8'h00, 1'b1, 8'h60);
        xfer(8'h20, 1'b1, 8'h48);
        xfer(8'h28, 1'b1, 8'h01);
        xfer(8'h24, 1'b1, 8'h00);
        xfer(8'h00, 1'b1, 8'h61);
        repeat (16) @(posedge mclk_i);
        meas(40);
        `CHK(hi, 10)
        `CHK(irq_ch, 2'b01)
        xfer(8'h24, 1'b1, 8'h80);
        xfer(8'h28, 1'b1, 8'h01);
        repeat (16) @(posedge mclk_i);
        meas(40);
        `CHK(hi, 0)
        xfer(8'h24, 1'b1, 8'h00);
        xfer(8'h28, 1'b1, 8'h05);
        repeat (16) @(posedge mclk_i);
        meas(40);
        `CHK(hi, 40)
        close_out();
    end
endmodule // testbench
